/* File: hw/ufl_line_control.sv */
`timescale 1ns/100ps
// Operation
// [R1] Mode 0: receive_ready_n low while any character is held, else high.
// [R2] Mode 1: transmit_ready_n high only when transmit FIFO is full.
// [R3] Mode 1: receive_ready_n low on trigger or timeout, high once empty.
// [R4] Trigger field picks 1, 4, 8 or 14 characters; resets to 1.
// [R5] Receive data interrupt at threshold; FIFO keeps filling beyond it.
// [R6] Identification read returns highest of four priority levels.
// [R7] Identification read clears only the source it reported.
// [R8] Codes: line 0110, data 0100, timeout 1100, tx empty 0010, modem 0000.
// [R9] Identification bit 0 low while pending, high otherwise and at reset.
// [R10] Bits 7:6 show FIFO enable, bits 5:4 read zero.
// [R11] Two low format bits select 5 to 8 data bits, reset 5.
// [R12] Stop bit: one, or 1.5 for 5 bits, else two.
// [R13] Parity enable adds parity on transmit and checks on receive.
// [R14] Parity select: zero odd, one even; both ends must agree.
// [R15] Force bit makes parity the inverse of the select bit.
// [R16] Break bit holds serial output low until cleared.
// [R17] Format bit 7 maps divisor latch in place of normal registers.
// [R18] terminal_ready_n is the inverse of modem control bit 0.
// [R19] request_to_send_n is the inverse of modem control bit 1.
// [R20] Modem control bit 2 drives internal ring indicator in loopback only.
// [R21] Modem control bit 4 enables local loopback, off by default.
// [R22] Modem control bit 3 enables the interrupt output driver.
// [R23] Mode 0: transmit_ready_n low when transmitter empty, high once loaded.
// [R24] FIFO control bit 0 gates other fields; bit 3 selects mode one.
// [R25] Timeout after four idle character times with data below threshold.
// [R26] Host rereads identification until bit 0 is one.
module ufl_line_control #(
  parameter int TX_DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic [4:0] rx_count_i,
  input wire logic [4:0] tx_count_i,
  input wire logic rx_push_i,
  input wire logic bit_tick_i,
  input wire logic line_irq_i,
  input wire logic modem_irq_i,
  input wire logic [3:0] irq_enable_i,
  input wire logic tx_serial_i,
  input wire logic [7:0] tx_data_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_parity_i,
  output logic receive_ready_n_o,
  output logic transmit_ready_n_o,
  output logic irq_o,
  output logic irq_oe_o,
  output logic terminal_ready_n_o,
  output logic request_to_send_n_o,
  output logic ring_indicator_n_o,
  output logic carrier_detect_n_o,
  output logic loopback_o,
  output logic tx_serial_o,
  output logic [3:0] data_bits_o,
  output logic stop_half_o,
  output logic stop_two_o,
  output logic parity_en_o,
  output logic tx_parity_o,
  output logic rx_parity_err_o,
  output logic divisor_access_o,
  output logic fifo_en_o,
  output logic rx_fifo_clr_o,
  output logic tx_fifo_clr_o,
  output logic rx_pop_o
);
  import ufl_pkg::*;

  typedef struct packed {
    logic fifo_en;
    logic mode1;
    logic [1:0] trig;
    logic [7:0] lfc;
    logic [4:0] mlc;
    logic txe_pend;
    logic tx_empty_prev;
    logic rto_pend;
    logic rx_rdy;
    logic rx_clr;
    logic tx_clr;
    logic [7:0] rdata;
  } ufl_state_t;

  ufl_state_t s_q;
  ufl_state_t s_d;

  logic rd_acc;
  logic wr_acc;
  logic id_read;
  logic mode1;
  logic [4:0] transmit_holding;
  logic [3:0] id_code;
  logic any_pend;
  logic src_line;
  logic src_rxd;
  logic src_rto;
  logic src_txe;
  logic src_modem;
  logic tx_empty;
  logic txe_set;
  logic tmr_active;
  logic tmr_expired;
  logic [3:0] frame_bits;
  logic [7:0] tmr_limit;
  logic [7:0] data_mask;
  logic [7:0] tx_masked;
  logic [7:0] rx_masked;
  logic rx_expect;

  // ****************************************
  // Bus decode
  // ****************************************
  assign rd_acc = !cs_n_i && rd_i;
  assign wr_acc = !cs_n_i && wr_i;
  assign id_read = rd_acc && addr_i == UFL_ADDR_IDENT && !s_q.lfc[UFL_LF_DIV];
  assign rx_pop_o = rd_acc && addr_i == UFL_ADDR_HOLD
                    && !s_q.lfc[UFL_LF_DIV]; // [R17]
  assign mode1 = s_q.fifo_en && s_q.mode1; // [R24]

  // ****************************************
  // Receive threshold
  // ****************************************
  always_comb begin
    case (s_q.trig) // [R4]
      2'h0: transmit_holding = UFL_TRIG_1;
      2'h1: transmit_holding = UFL_TRIG_4;
      2'h2: transmit_holding = UFL_TRIG_8;
      2'h3: transmit_holding = UFL_TRIG_14;
      default: transmit_holding = UFL_TRIG_1;
    endcase
  end

  // ****************************************
  // Interrupt sources and priority
  // ****************************************
  assign tx_empty = tx_count_i == 5'h00;
  assign txe_set = tx_empty && !s_q.tx_empty_prev;
  assign src_line = line_irq_i && irq_enable_i[2];
  assign src_rxd = irq_enable_i[0] && rx_count_i != 5'h00
                   && rx_count_i >= (s_q.fifo_en ? transmit_holding : UFL_TRIG_1); // [R5]
  assign src_rto = irq_enable_i[0] && s_q.rto_pend;
  assign src_txe = irq_enable_i[1] && s_q.txe_pend;
  assign src_modem = irq_enable_i[3] && modem_irq_i;
  assign any_pend = src_line || src_rxd || src_rto || src_txe || src_modem;

  always_comb begin
    if (src_line) begin // [R6] [R8]
      id_code = UFL_ID_LINE;
    end else if (src_rxd) begin
      id_code = UFL_ID_RXDATA;
    end else if (src_rto) begin
      id_code = UFL_ID_RXTIME;
    end else if (src_txe) begin
      id_code = UFL_ID_TXEMPTY;
    end else if (src_modem) begin
      id_code = UFL_ID_MODEM;
    end else begin
      id_code = UFL_ID_NONE; // [R9]
    end
  end

  // ****************************************
  // Receive timeout timer
  // ****************************************
  assign frame_bits = 4'h2 + {2'h0, s_q.lfc[1:0]} + 4'h5
                      + {3'h0, s_q.lfc[UFL_LF_PAR_EN]}
                      + {3'h0, s_q.lfc[UFL_LF_STOP]};
  assign tmr_limit = {4'h0, frame_bits} * {5'h00, UFL_TIMEOUT_CHARS};
  assign tmr_active = s_q.fifo_en && rx_count_i != 5'h00
                      && rx_count_i < transmit_holding; // [R25]

  ufl_rx_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .active_i(tmr_active),
    .restart_i(rx_push_i || rx_pop_o),
    .bit_tick_i(bit_tick_i),
    .limit_i(tmr_limit),
    .expired_o(tmr_expired)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.rx_clr = 1'b0;
    s_d.tx_clr = 1'b0;
    s_d.tx_empty_prev = tx_empty;
    if (wr_acc && !s_q.lfc[UFL_LF_DIV]) begin
      if (addr_i == UFL_ADDR_IDENT) begin
        s_d.fifo_en = wdata_i[UFL_FC_ENABLE];
        if (wdata_i[UFL_FC_ENABLE]) begin // [R24]
          s_d.mode1 = wdata_i[UFL_FC_MODE];
          s_d.trig = wdata_i[UFL_FC_TRIG_HI:UFL_FC_TRIG_LO];
          s_d.rx_clr = wdata_i[UFL_FC_RXCLR];
          s_d.tx_clr = wdata_i[UFL_FC_TXCLR];
        end
      end
      if (addr_i == UFL_ADDR_MLC) begin
        s_d.mlc = wdata_i[4:0];
      end
    end
    if (wr_acc && addr_i == UFL_ADDR_LFC) begin
      s_d.lfc = wdata_i;
    end
    // Clear by read of the reported source, set wins
    if (!tx_empty) begin
      s_d.txe_pend = 1'b0;
    end else if (id_read && id_code == UFL_ID_TXEMPTY) begin
      s_d.txe_pend = 1'b0; // [R7]
    end
    if (txe_set) begin
      s_d.txe_pend = 1'b1;
    end
    if (rx_push_i || rx_pop_o || (id_read && id_code == UFL_ID_RXTIME)) begin
      s_d.rto_pend = 1'b0; // [R7]
    end
    if (tmr_expired) begin
      s_d.rto_pend = 1'b1; // [R25]
    end
    // Mode 1 receive ready latch
    if (rx_count_i >= transmit_holding || s_d.rto_pend) begin
      s_d.rx_rdy = 1'b1; // [R3]
    end else if (rx_count_i == 5'h00) begin
      s_d.rx_rdy = 1'b0;
    end
    if (rd_acc) begin
      case (addr_i)
        UFL_ADDR_IDENT: s_d.rdata = s_q.lfc[UFL_LF_DIV] ? 8'h00
          : {{2{s_q.fifo_en}}, 2'h0, id_code}; // [R10]
        UFL_ADDR_LFC: s_d.rdata = s_q.lfc;
        UFL_ADDR_MLC: s_d.rdata = {3'h0, s_q.mlc};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.trig <= UFL_TRIG_RST;
      s_q.lfc <= UFL_LFC_RST;
      s_q.mlc <= UFL_MLC_RST;
      s_q.tx_empty_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Pins and format outputs
  // ****************************************
  assign rdata_o = s_q.rdata;
  assign fifo_en_o = s_q.fifo_en;
  assign rx_fifo_clr_o = s_q.rx_clr;
  assign tx_fifo_clr_o = s_q.tx_clr;
  assign receive_ready_n_o = mode1 ? !s_q.rx_rdy
                           : rx_count_i == 5'h00; // [R1] [R3]
  assign transmit_ready_n_o = mode1
    ? tx_count_i == 5'(TX_DEPTH) // [R2]
    : !tx_empty; // [R23]
  assign irq_oe_o = s_q.mlc[UFL_ML_IRQ_EN]; // [R22]
  assign irq_o = irq_oe_o && any_pend;
  assign loopback_o = s_q.mlc[UFL_ML_LOOP]; // [R21]
  assign terminal_ready_n_o = !s_q.mlc[UFL_ML_TERM]; // [R18]
  assign request_to_send_n_o = !s_q.mlc[UFL_ML_RTS]; // [R19]
  assign ring_indicator_n_o = !(loopback_o && s_q.mlc[UFL_ML_RING]); // [R20]
  assign carrier_detect_n_o = !(loopback_o && s_q.mlc[UFL_ML_IRQ_EN]);
  assign tx_serial_o = tx_serial_i && !s_q.lfc[UFL_LF_BREAK]; // [R16]
  assign divisor_access_o = s_q.lfc[UFL_LF_DIV]; // [R17]
  assign data_bits_o = 4'h5 + {2'h0, s_q.lfc[1:0]}; // [R11]
  assign stop_half_o = s_q.lfc[UFL_LF_STOP] && s_q.lfc[1:0] == 2'h0; // [R12]
  assign stop_two_o = s_q.lfc[UFL_LF_STOP] && s_q.lfc[1:0] != 2'h0;
  assign parity_en_o = s_q.lfc[UFL_LF_PAR_EN]; // [R13]

  // ****************************************
  // Parity generation and check
  // ****************************************
  assign data_mask = 8'hff >> (3'h3 - {1'b0, s_q.lfc[1:0]});
  assign tx_masked = tx_data_i & data_mask;
  assign rx_masked = rx_data_i & data_mask;
  assign tx_parity_o = s_q.lfc[UFL_LF_PAR_FORCE] ? !s_q.lfc[UFL_LF_PAR_SEL]
    : (s_q.lfc[UFL_LF_PAR_SEL] ? ^tx_masked : !(^tx_masked)); // [R14] [R15]
  assign rx_expect = s_q.lfc[UFL_LF_PAR_FORCE] ? !s_q.lfc[UFL_LF_PAR_SEL]
    : (s_q.lfc[UFL_LF_PAR_SEL] ? ^rx_masked : !(^rx_masked)); // [R15]
  assign rx_parity_err_o = parity_en_o && rx_parity_i != rx_expect; // [R13]

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_rx_ready_mode0: assert property ( // [R1]
    !mode1 |-> receive_ready_n_o == (rx_count_i == 5'h00))
    else $error("receive ready wrong in mode 0");
  a_tx_ready_mode1: assert property ( // [R2]
    mode1 && tx_count_i < 5'(TX_DEPTH) |-> !transmit_ready_n_o)
    else $error("transmit ready high with free space");
  a_rx_ready_mode1: assert property ( // [R3]
    mode1 && rx_count_i >= transmit_holding ##1 mode1 |-> !receive_ready_n_o)
    else $error("receive ready not asserted at trigger");
  a_trig_level: assert property ( // [R4]
    s_q.trig == 2'h3 |-> transmit_holding == 5'h0e)
    else $error("trigger level 14 wrong");
  a_line_first: assert property ( // [R6]
    src_line && id_read |=> rdata_o[3:0] == 4'h6)
    else $error("line status not reported first");
  a_txe_clear: assert property ( // [R7]
    id_read && id_code == UFL_ID_TXEMPTY && !txe_set |=> !s_q.txe_pend)
    else $error("tx empty not cleared by read");
  a_none_pend: assert property ( // [R9]
    !any_pend && id_read |=> rdata_o[3:0] == 4'h1 && rdata_o[5:4] == 2'h0)
    else $error("idle identification wrong");
  a_break_low: assert property ( // [R16]
    s_q.lfc[6] |-> !tx_serial_o)
    else $error("break not forcing low");
  a_irq_drive: assert property ( // [R22]
    !s_q.mlc[3] |-> !irq_oe_o && !irq_o)
    else $error("interrupt driven while disabled");
  a_fcr_gate: assert property ( // [R24]
    wr_acc && addr_i == 3'h2 && !s_q.lfc[7] && !wdata_i[0]
    |=> $stable(s_q.trig) && !s_q.fifo_en)
    else $error("FIFO control written while disabled");
  a_rto_set: assert property ( // [R25]
    tmr_expired |=> s_q.rto_pend)
    else $error("timeout not latched");

  c_mode1_trig: cover property (mode1 && rx_count_i == transmit_holding);
  c_timeout: cover property (tmr_expired);
  c_two_reads: cover property (id_read && src_line && src_txe);
endmodule

/* File: hw/ufl_pkg.sv */
package ufl_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [2:0] UFL_ADDR_HOLD = 3'h0;
  localparam logic [2:0] UFL_ADDR_IDENT = 3'h2;
  localparam logic [2:0] UFL_ADDR_LFC = 3'h3;
  localparam logic [2:0] UFL_ADDR_MLC = 3'h4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int UFL_FC_ENABLE = 0;
  localparam int UFL_FC_RXCLR = 1;
  localparam int UFL_FC_TXCLR = 2;
  localparam int UFL_FC_MODE = 3;
  localparam int UFL_FC_TRIG_LO = 6;
  localparam int UFL_FC_TRIG_HI = 7;
  localparam int UFL_LF_STOP = 2;
  localparam int UFL_LF_PAR_EN = 3;
  localparam int UFL_LF_PAR_SEL = 4;
  localparam int UFL_LF_PAR_FORCE = 5;
  localparam int UFL_LF_BREAK = 6;
  localparam int UFL_LF_DIV = 7;
  localparam int UFL_ML_TERM = 0;
  localparam int UFL_ML_RTS = 1;
  localparam int UFL_ML_RING = 2;
  localparam int UFL_ML_IRQ_EN = 3;
  localparam int UFL_ML_LOOP = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] UFL_LFC_RST = 8'h00;
  localparam logic [4:0] UFL_MLC_RST = 5'h00;
  localparam logic [1:0] UFL_TRIG_RST = 2'h0;

  // ****************************************
  // Receive trigger levels
  // ****************************************
  localparam logic [4:0] UFL_TRIG_1 = 5'h01;
  localparam logic [4:0] UFL_TRIG_4 = 5'h04;
  localparam logic [4:0] UFL_TRIG_8 = 5'h08;
  localparam logic [4:0] UFL_TRIG_14 = 5'h0e;

  // ****************************************
  // Identification codes, bits 3 to 0
  // ****************************************
  localparam logic [3:0] UFL_ID_LINE = 4'h6;
  localparam logic [3:0] UFL_ID_RXDATA = 4'h4;
  localparam logic [3:0] UFL_ID_RXTIME = 4'hc;
  localparam logic [3:0] UFL_ID_TXEMPTY = 4'h2;
  localparam logic [3:0] UFL_ID_MODEM = 4'h0;
  localparam logic [3:0] UFL_ID_NONE = 4'h1;

  // ****************************************
  // Timeout in character times
  // ****************************************
  localparam logic [2:0] UFL_TIMEOUT_CHARS = 3'h4;

endpackage

/* File: hw/ufl_rx_timer.sv */
`timescale 1ns/100ps
module ufl_rx_timer (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic active_i,
  input wire logic restart_i,
  input wire logic bit_tick_i,
  input wire logic [7:0] limit_i,
  output logic expired_o
);
  import ufl_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic fired;
    logic expired;
  } ufl_tmr_t;

  ufl_tmr_t s_q;
  ufl_tmr_t s_d;

  // ****************************************
  // Bit time counter
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.expired = 1'b0;
    if (!active_i || restart_i) begin
      s_d.cnt = 8'h00;
      s_d.fired = 1'b0;
    end else if (bit_tick_i && !s_q.fired) begin
      if (s_q.cnt + 8'h01 >= limit_i) begin // [R25]
        s_d.expired = 1'b1;
        s_d.fired = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired_o = s_q.expired;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_timer_stop: assert property (!active_i |=> !expired_o) // [R25]
    else $error("timeout fired while inactive");
endmodule

/* File: sim/ufl_fifo_peer.sv */
`timescale 1ns/100ps
// ****************************************
// Fill counts of both FIFOs on the serial side
// ****************************************
module ufl_fifo_peer (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic rx_put_i,
  input wire logic rx_pop_i,
  input wire logic rx_clr_i,
  input wire logic tx_put_i,
  input wire logic tx_take_i,
  input wire logic tx_clr_i,
  output logic rx_push_o,
  output logic [4:0] rx_count_o,
  output logic [4:0] tx_count_o
);
  // Arrivals stop only when full, not at the trigger
  assign rx_push_o = rx_put_i && (rx_count_o != 5'h10);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_count_o <= 5'h00;
      tx_count_o <= 5'h00;
    end else begin
      if (rx_clr_i) begin
        rx_count_o <= 5'h00;
      end else if (rx_push_o && !rx_pop_i) begin
        rx_count_o <= rx_count_o + 5'h01;
      end else if (rx_pop_i && !rx_push_o && rx_count_o != 5'h00) begin
        rx_count_o <= rx_count_o - 5'h01;
      end
      if (tx_clr_i) begin
        tx_count_o <= 5'h00;
      end else if (tx_put_i && tx_count_o != 5'h10) begin
        tx_count_o <= tx_count_o + 5'h01;
      end else if (tx_take_i && tx_count_o != 5'h00) begin
        tx_count_o <= tx_count_o - 5'h01;
      end
    end
  end
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import ufl_pkg::*;
  typedef struct packed {
    logic [7:0] set;
    logic [8:0] exp;
  } ufl_row_t;
  // ****************************************
  // Rows: format {bits,half,two,par_en,par,ser}; modem pins
  // ****************************************
  ufl_row_t fmt [8] = '{'{8'h00, 9'h0a1}, '{8'h0d, 9'h0cf},
    '{8'h1e, 9'h0ed}, '{8'h1c, 9'h0b7}, '{8'h2b, 9'h107},
    '{8'h3b, 9'h105}, '{8'h43, 9'h100}, '{8'h0b, 9'h107}};
  ufl_row_t mdm [6] = '{'{8'h00, 9'h03c}, '{8'h03, 9'h00c},
    '{8'h04, 9'h03c}, '{8'h14, 9'h036}, '{8'h18, 9'h03b},
    '{8'h08, 9'h03d}};
  int trig [4] = '{1, 4, 8, 14};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cs_n = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, txd = 8'h3f, rdata;
  logic bit_tick = 1'b0, line_irq = 1'b0, modem_irq = 1'b0, rxp = 1'b0;
  logic rx_put = 1'b0, tx_put = 1'b0, tx_take = 1'b0;
  logic [3:0] irq_en = 4'h0;
  logic [3:0] dbits;
  logic [4:0] rx_cnt, tx_cnt;
  logic rx_push, rx_pop, rx_clr, tx_clr, rrdy_n, trdy_n, irq, irq_oe;
  logic term_n, rts_n, ri_n, cd_n, loopb, txo, half, two, pe, txpar;
  logic perr, div, fen;
  int fails = 0, compares = 0, cycles = 0;

  always #2 clk_sys = ~clk_sys;

  ufl_fifo_peer u_ufl_fifo_peer (.clk_sys_i(clk_sys), .rstn_i(rstn),
    .rx_put_i(rx_put), .rx_pop_i(rx_pop), .rx_clr_i(rx_clr),
    .tx_put_i(tx_put), .tx_take_i(tx_take), .tx_clr_i(tx_clr),
    .rx_push_o(rx_push), .rx_count_o(rx_cnt), .tx_count_o(tx_cnt));

  ufl_line_control #(.TX_DEPTH(16)) u_ufl_line_control (
    .clk_sys_i(clk_sys), .rstn_i(rstn), .cs_n_i(cs_n), .rd_i(rd),
    .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .rx_count_i(rx_cnt), .tx_count_i(tx_cnt), .rx_push_i(rx_push),
    .bit_tick_i(bit_tick), .line_irq_i(line_irq),
    .modem_irq_i(modem_irq), .irq_enable_i(irq_en),
    .tx_serial_i(1'b1), .tx_data_i(txd), .rx_data_i(txd),
    .rx_parity_i(rxp), .receive_ready_n_o(rrdy_n),
    .transmit_ready_n_o(trdy_n), .irq_o(irq), .irq_oe_o(irq_oe),
    .terminal_ready_n_o(term_n), .request_to_send_n_o(rts_n),
    .ring_indicator_n_o(ri_n), .carrier_detect_n_o(cd_n),
    .loopback_o(loopb), .tx_serial_o(txo), .data_bits_o(dbits),
    .stop_half_o(half), .stop_two_o(two), .parity_en_o(pe),
    .tx_parity_o(txpar), .rx_parity_err_o(perr),
    .divisor_access_o(div), .fifo_en_o(fen), .rx_fifo_clr_o(rx_clr),
    .tx_fifo_clr_o(tx_clr), .rx_pop_o(rx_pop));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [7:0] d);
    @(negedge clk_sys);
    cs_n = 1'b0;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk_sys);
    cs_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    // Idle cycle lets clear pulses and ready latches settle
    @(negedge clk_sys);
  endtask

  task automatic rd_reg(input string nm, input logic [2:0] a,
                        input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {1'b0, e}, {1'b0, rdata});
  endtask

  task automatic pulse(ref logic s, input int n);
    repeat (n) begin
      @(negedge clk_sys);
      s = 1'b1;
    end
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(negedge clk_sys);
    chk("reset pins", 9'h11e, {rrdy_n, trdy_n, irq, irq_oe, term_n,
        rts_n, ri_n, cd_n, loopb});
    rstn = 1'b1;
    rd_reg("ident reset", UFL_ADDR_IDENT, 8'h01);
    rd_reg("format reset", UFL_ADDR_LFC, 8'h00);
    foreach (fmt[i]) begin
      bus(1'b1, UFL_ADDR_LFC, fmt[i].set);
      rxp = fmt[i].exp[1];
      @(negedge clk_sys);
      chk("format", fmt[i].exp, {dbits, half, two, pe, txpar & pe,
          txo});
      chk("parity err", 9'h000, {8'h00, perr & pe});
    end
    rd_reg("format back", UFL_ADDR_LFC, 8'h0b);
    rxp = 1'b0;
    @(negedge clk_sys);
    chk("parity err", 9'h001, {8'h00, perr});
    foreach (mdm[i]) begin
      bus(1'b1, UFL_ADDR_MLC, mdm[i].set);
      @(negedge clk_sys);
      chk("modem pins", mdm[i].exp, {term_n, rts_n, ri_n, cd_n, loopb,
          irq_oe});
    end
    rd_reg("modem back", UFL_ADDR_MLC, 8'h08);
    rd_reg("unmapped", 3'h7, 8'h00);
    bus(1'b1, UFL_ADDR_LFC, 8'h00);
    pulse(rx_put, 1);
    chk("receive_ready_n m0", 9'h000, {8'h00, rrdy_n});
    pulse(tx_put, 1);
    chk("transmit_ready_n m0", 9'h001, {8'h00, trdy_n});
    bus(1'b0, UFL_ADDR_HOLD, 8'h00);
    pulse(tx_take, 1);
    chk("rdy m0 empty", 9'h002, {7'h00, rrdy_n, trdy_n});
    irq_en = 4'h1;
    for (int t = 0; t < 4; t++) begin
      bus(1'b1, UFL_ADDR_IDENT, {t[1:0], 6'h0f});
      pulse(rx_put, trig[t] - 1);
      rd_reg("id below", UFL_ADDR_IDENT, 8'hc1);
      chk("below", 9'h003, {7'h00, rrdy_n, fen});
      pulse(rx_put, 1);
      rd_reg("id at", UFL_ADDR_IDENT, 8'hc4);
      chk("receive_ready_n at", 9'h000, {8'h00, rrdy_n});
    end
    pulse(rx_put, 3);
    chk("keeps filling", 9'h010, {4'h0, rx_cnt});
    repeat (15) bus(1'b0, UFL_ADDR_HOLD, 8'h00);
    rd_reg("id drained", UFL_ADDR_IDENT, 8'hc1);
    chk("receive_ready_n held", 9'h000, {8'h00, rrdy_n});
    bus(1'b0, UFL_ADDR_HOLD, 8'h00);
    chk("receive_ready_n empty", 9'h001, {8'h00, rrdy_n});
    pulse(tx_put, 15);
    chk("transmit_ready_n room", 9'h000, {8'h00, trdy_n});
    pulse(tx_put, 1);
    chk("transmit_ready_n full", 9'h001, {8'h00, trdy_n});
    bus(1'b1, UFL_ADDR_IDENT, 8'h4f);
    pulse(rx_put, 1);
    pulse(bit_tick, 26);
    chk("no timeout", 9'h001, {8'h00, rrdy_n});
    pulse(bit_tick, 4);
    chk("timeout rdy", 9'h000, {8'h00, rrdy_n});
    rd_reg("id timeout", UFL_ADDR_IDENT, 8'hcc);
    rd_reg("id cleared", UFL_ADDR_IDENT, 8'hc1);
    bus(1'b0, UFL_ADDR_HOLD, 8'h00);
    bus(1'b1, UFL_ADDR_IDENT, 8'h01);
    irq_en = 4'hf;
    pulse(tx_put, 1);
    pulse(tx_take, 1);
    line_irq = 1'b1;
    modem_irq = 1'b1;
    pulse(rx_put, 1);
    chk("irq on", 9'h001, {8'h00, irq});
    rd_reg("id line", UFL_ADDR_IDENT, 8'hc6);
    line_irq = 1'b0;
    rd_reg("id rx", UFL_ADDR_IDENT, 8'hc4);
    bus(1'b0, UFL_ADDR_HOLD, 8'h00);
    rd_reg("id tx", UFL_ADDR_IDENT, 8'hc2);
    rd_reg("id modem", UFL_ADDR_IDENT, 8'hc0);
    modem_irq = 1'b0;
    rd_reg("id none", UFL_ADDR_IDENT, 8'hc1);
    chk("irq off", 9'h000, {8'h00, irq});
    bus(1'b1, UFL_ADDR_IDENT, 8'hc8);
    chk("fifo off", 9'h000, {8'h00, fen});
    rd_reg("id no fifo", UFL_ADDR_IDENT, 8'h01);
    bus(1'b1, UFL_ADDR_LFC, 8'h80);
    rd_reg("id hidden", UFL_ADDR_IDENT, 8'h00);
    bus(1'b1, UFL_ADDR_MLC, 8'h03);
    chk("div map", 9'h003, {7'h00, div, term_n});
    bus(1'b1, UFL_ADDR_LFC, 8'h00);
    rd_reg("id shown", UFL_ADDR_IDENT, 8'h01);
    bus(1'b1, UFL_ADDR_MLC, 8'h13);
    rstn = 1'b0;
    @(negedge clk_sys);
    chk("mid reset", 9'h03c, {term_n, rts_n, ri_n, cd_n, loopb,
        irq_oe});
    rstn = 1'b1;
    rd_reg("modem reset", UFL_ADDR_MLC, 8'h00);
    rd_reg("format reset 2", UFL_ADDR_LFC, 8'h00);
    end_of_test();
  end
endmodule
